// >>> rtl/dma_channel_control.sv
`timescale 1ns/1ps
module dma_channel_control #(
  parameter int unsigned NUM_CH = 8,
  parameter int unsigned CH_ID  = 7
) (
  input  wire logic                               clock,
  input  wire logic                               rst_n,
  input  wire logic [31:0]                        reg_addr,
  input  wire logic [15:0]                        reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [15:0]                        reg_rdata,
  input  wire logic                               trusted_mode,
  input  wire logic                               periph_req,
  output logic                                    periph_ack,
  input  wire logic [NUM_CH-1:0]                  peer_req,
  input  wire logic [NUM_CH*dma_channel_pkg::PRIO_W-1:0] peer_prio,
  output logic                                    bus_want,
  output logic                                    bus_hold,
  output dma_channel_pkg::bus_cmd_t               bus_cmd,
  input  wire logic                               bus_ack,
  input  wire logic [31:0]                        bus_rdata,
  output logic                                    irq
);
  import dma_channel_pkg::*;

  // forced fields while acting as the trusted channel
  function automatic channel_control_t effective(input channel_control_t c, input logic t);
    channel_control_t e;
    e          = c;
    e.reserved = 2'h0;
    if (t) begin
      e.fill_mode            = 1'b0;
      e.yield_cycles         = 1'b0;
      e.request_trigger_mode = 1'b0;
      e.transfer_width       = WIDTH_TRUSTED;
    end
    return e;
  endfunction : effective

  // byte offset of the current item; reserved width steps like a word
  function automatic logic [31:0] step_offset(input logic en, input logic [15:0] idx,
                                              input logic [1:0] w);
    logic [31:0] base;
    base = {16'h0000, idx};
    if (!en) return 32'h0000_0000;
    case (w)
      WIDTH_BYTE: return base;
      WIDTH_HALF: return {base[30:0], 1'b0};
      default:    return {base[29:0], 2'h0};
    endcase
  endfunction : step_offset

  // this channel wins when no peer beats it on priority or number
  function automatic logic wins(input logic [NUM_CH-1:0] req,
                                input logic [NUM_CH*PRIO_W-1:0] pr,
                                input logic [PRIO_W-1:0] mine);
    logic w;
    logic [PRIO_W-1:0] p;
    w = 1'b1;
    for (int j = 0; j < NUM_CH; j++) begin
      p = pr[j*PRIO_W +: PRIO_W];
      if (j != CH_ID && req[j]) begin
        if (p > mine) w = 1'b0;
        if (p == mine && j < CH_ID) w = 1'b0;
      end
    end
    return w;
  endfunction : wins

  channel_control_t ctrl_r, ctrl_nxt, eff;
  chan_state_t      state_r, state_nxt;
  logic [15:0]      src_lo_r, src_lo_nxt, src_hi_r, src_hi_nxt;
  logic [15:0]      dst_lo_r, dst_lo_nxt, dst_hi_r, dst_hi_nxt;
  logic [15:0]      thr_r, thr_nxt, len_r, len_nxt, idx_r, idx_nxt;
  logic [15:0]      rdata_r, rdata_nxt;
  logic [31:0]      data_r, data_nxt;
  logic             sync1_r, sync1_nxt, sync2_r, sync2_nxt, prev_r, prev_nxt;
  logic             edge_pend_r, edge_pend_nxt;
  logic             ack_r, ack_nxt, irq_r, irq_nxt;
  logic             want_r, want_nxt, hold_r, hold_nxt;
  bus_cmd_t         cmd_r, cmd_nxt;
  logic             req_seen, loop_ok, last_item, keep_bus;
  logic [31:0]      src_addr, dst_addr;

  assign reg_rdata  = rdata_r;
  assign periph_ack = ack_r;
  assign irq        = irq_r;
  assign bus_want   = want_r;
  assign bus_hold   = hold_r;
  assign bus_cmd    = cmd_r;

  always_comb begin
    eff      = effective(ctrl_r, trusted_mode);
    src_addr = {src_hi_r, src_lo_r} + step_offset(eff.source_step_en, idx_r,
                                                  eff.transfer_width);
    dst_addr = {dst_hi_r, dst_lo_r} + step_offset(eff.dest_step_en, idx_r,
                                                  eff.transfer_width);
    req_seen = eff.request_sensitivity ? edge_pend_r : sync2_r;
    loop_ok  = eff.loop_mode && eff.request_trigger_mode;
    last_item = (idx_r == len_r);
    // fill and blocking mode keep the bus between items
    keep_bus = eff.fill_mode || (!eff.yield_cycles && !eff.request_trigger_mode);

    ctrl_nxt      = ctrl_r;
    src_lo_nxt    = src_lo_r;
    src_hi_nxt    = src_hi_r;
    dst_lo_nxt    = dst_lo_r;
    dst_hi_nxt    = dst_hi_r;
    thr_nxt       = thr_r;
    len_nxt       = len_r;
    idx_nxt       = idx_r;
    data_nxt      = data_r;
    state_nxt     = state_r;
    want_nxt      = want_r;
    hold_nxt      = hold_r;
    cmd_nxt       = cmd_r;
    ack_nxt       = 1'b0;
    irq_nxt       = 1'b0;
    sync1_nxt     = periph_req;
    sync2_nxt     = sync1_r;
    prev_nxt      = sync2_r;
    edge_pend_nxt = edge_pend_r;
    rdata_nxt     = 16'h0000;

    if (reg_wr) begin
      case (reg_addr)
        OFS_SRC_LO:    src_lo_nxt = reg_wdata;
        OFS_SRC_HI:    src_hi_nxt = reg_wdata;
        OFS_DST_LO:    dst_lo_nxt = reg_wdata;
        OFS_DST_HI:    dst_hi_nxt = reg_wdata;
        OFS_THRESHOLD: thr_nxt    = reg_wdata;
        OFS_LENGTH:    len_nxt    = reg_wdata;
        OFS_CONTROL:   ctrl_nxt   = channel_control_t'(reg_wdata & CONTROL_WMASK);
        default:       ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_SRC_LO:    rdata_nxt = src_lo_r;
        OFS_SRC_HI:    rdata_nxt = src_hi_r;
        OFS_DST_LO:    rdata_nxt = dst_lo_r;
        OFS_DST_HI:    rdata_nxt = dst_hi_r;
        OFS_THRESHOLD: rdata_nxt = thr_r;
        OFS_LENGTH:    rdata_nxt = len_r;
        OFS_CONTROL:   rdata_nxt = eff;
        OFS_INDEX:     rdata_nxt = idx_r;
        default:       rdata_nxt = 16'h0000;
      endcase
    end

    case (state_r)
      ST_IDLE: begin
        want_nxt      = 1'b0;
        hold_nxt      = 1'b0;
        // an edge seen while the channel is off must not start a later transfer
        edge_pend_nxt = 1'b0;
        if (eff.channel_on) begin
          state_nxt = eff.request_trigger_mode ? ST_WAIT_REQ : ST_ARB;
        end
      end
      ST_WAIT_REQ: begin
        if (!eff.channel_on) begin
          state_nxt = ST_IDLE;
          hold_nxt  = 1'b0;
        end else if (req_seen) begin
          edge_pend_nxt = 1'b0;
          state_nxt     = ST_ARB;
        end
      end
      ST_ARB: begin
        if (!eff.channel_on) begin
          state_nxt = ST_IDLE;
          want_nxt  = 1'b0;
        end else if (hold_r || wins(peer_req, peer_prio, eff.channel_priority)) begin
          want_nxt      = 1'b0;
          hold_nxt      = 1'b1;
          cmd_nxt.valid = 1'b1;
          cmd_nxt.size  = eff.transfer_width;
          cmd_nxt.wdata = data_r;
          // fill mode fetches the source only for the first item
          if (eff.fill_mode && idx_r != 16'h0000) begin
            cmd_nxt.write = 1'b1;
            cmd_nxt.addr  = dst_addr;
            state_nxt     = ST_WRITE;
          end else begin
            cmd_nxt.write = 1'b0;
            cmd_nxt.addr  = src_addr;
            state_nxt     = ST_READ;
          end
        end else begin
          want_nxt = 1'b1;
        end
      end
      ST_READ: begin
        if (bus_ack) begin
          data_nxt      = bus_rdata;
          cmd_nxt.write = 1'b1;
          cmd_nxt.addr  = dst_addr;
          cmd_nxt.wdata = bus_rdata;
          state_nxt     = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (bus_ack) begin
          cmd_nxt.valid = 1'b0;
          cmd_nxt.write = 1'b0;
          ack_nxt       = eff.request_trigger_mode;
          irq_nxt       = eff.completion_irq_en && (thr_r == idx_r);
          // the completion clear of channel_on is applied after any register write
          if (last_item) begin
            idx_nxt = 16'h0000;
            if (!loop_ok) begin
              ctrl_nxt.channel_on = 1'b0;
            end
          end else begin
            idx_nxt = idx_r + 16'h0001;
          end
          if ((last_item && !loop_ok) || !eff.channel_on) begin
            hold_nxt  = 1'b0;
            state_nxt = ST_IDLE;
          end else if (last_item && !eff.fill_mode) begin
            hold_nxt  = 1'b0;
            state_nxt = ST_WAIT_REQ;
          end else if (eff.yield_cycles && !eff.request_trigger_mode
                       && !eff.fill_mode) begin
            hold_nxt  = 1'b0;
            state_nxt = ST_YIELD;
          end else if (keep_bus) begin
            state_nxt = eff.request_trigger_mode ? ST_WAIT_REQ : ST_ARB;
          end else begin
            hold_nxt  = 1'b0;
            state_nxt = ST_WAIT_REQ;
          end
        end
      end
      ST_YIELD: begin
        // one cycle with the bus released so other masters get a turn
        state_nxt = eff.channel_on ? ST_ARB : ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        want_nxt  = 1'b0;
        hold_nxt  = 1'b0;
        cmd_nxt   = '0;
      end
    endcase

    // a new edge wins over the clear that consumes the previous one;
    // edges are only kept once the channel has left idle
    if (sync2_r && !prev_r && state_r != ST_IDLE) begin
      edge_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r      <= channel_control_t'(CONTROL_RESET);
      state_r     <= ST_IDLE;
      src_lo_r    <= WORD_RESET;
      src_hi_r    <= WORD_RESET;
      dst_lo_r    <= WORD_RESET;
      dst_hi_r    <= WORD_RESET;
      thr_r       <= WORD_RESET;
      len_r       <= WORD_RESET;
      idx_r       <= WORD_RESET;
      rdata_r     <= 16'h0000;
      data_r      <= 32'h0000_0000;
      sync1_r     <= 1'b0;
      sync2_r     <= 1'b0;
      prev_r      <= 1'b0;
      edge_pend_r <= 1'b0;
      ack_r       <= 1'b0;
      irq_r       <= 1'b0;
      want_r      <= 1'b0;
      hold_r      <= 1'b0;
      cmd_r       <= '0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      state_r     <= state_nxt;
      src_lo_r    <= src_lo_nxt;
      src_hi_r    <= src_hi_nxt;
      dst_lo_r    <= dst_lo_nxt;
      dst_hi_r    <= dst_hi_nxt;
      thr_r       <= thr_nxt;
      len_r       <= len_nxt;
      idx_r       <= idx_nxt;
      rdata_r     <= rdata_nxt;
      data_r      <= data_nxt;
      sync1_r     <= sync1_nxt;
      sync2_r     <= sync2_nxt;
      prev_r      <= prev_nxt;
      edge_pend_r <= edge_pend_nxt;
      ack_r       <= ack_nxt;
      irq_r       <= irq_nxt;
      want_r      <= want_nxt;
      hold_r      <= hold_nxt;
      cmd_r       <= cmd_nxt;
    end
  end

endmodule : dma_channel_control

// >>> rtl/dma_channel_pkg.sv
// Summary of operation
// - request sense: level when 0, rising edge when 1
// - fill mode writes first source item everywhere
// - fill transfer keeps the bus until done
// - trusted channel forces fill, yield, trigger, width
// - no yield, no trigger: back-to-back, bus held throughout
// - yield, no trigger or fill: one wait cycle between stores
// - highest three-bit priority wins the bus
// - equal priority: lower channel number wins
// - normal mode clears channel_on at completion
// - loop mode in trigger mode restarts with item_index zero
// - source steps 1, 2 or 4 when enabled
// - destination steps 1, 2 or 4 when enabled
// - trigger mode waits for peripheral request
// - interrupt only when completion_irq_en set
// - transfer_width encodes 1, 2, 4 bytes
// - channel_on enables the channel
// - item_index forms addresses, cleared at completion
// - transfer_length N moves N plus one items
// - interrupt when irq_threshold equals item_index
package dma_channel_pkg;

  localparam logic [31:0] OFS_SRC_LO    = 32'h5000_3570;
  localparam logic [31:0] OFS_SRC_HI    = 32'h5000_3572;
  localparam logic [31:0] OFS_DST_LO    = 32'h5000_3574;
  localparam logic [31:0] OFS_DST_HI    = 32'h5000_3576;
  localparam logic [31:0] OFS_THRESHOLD = 32'h5000_3578;
  localparam logic [31:0] OFS_LENGTH    = 32'h5000_357A;
  localparam logic [31:0] OFS_CONTROL   = 32'h5000_357C;
  localparam logic [31:0] OFS_INDEX     = 32'h5000_357E;

  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_WMASK = 16'h3FFF;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  localparam logic [1:0] WIDTH_BYTE    = 2'h0;
  localparam logic [1:0] WIDTH_HALF    = 2'h1;
  localparam logic [1:0] WIDTH_WORD    = 2'h2;
  localparam logic [1:0] WIDTH_TRUSTED = 2'h2;

  localparam int unsigned PRIO_W = 3;

  typedef struct packed {
    logic [1:0] reserved;
    logic       request_sensitivity;
    logic       fill_mode;
    logic       yield_cycles;
    logic [2:0] channel_priority;
    logic       loop_mode;
    logic       source_step_en;
    logic       dest_step_en;
    logic       request_trigger_mode;
    logic       completion_irq_en;
    logic [1:0] transfer_width;
    logic       channel_on;
  } channel_control_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_REQ, ST_ARB, ST_READ, ST_WRITE, ST_YIELD
  } chan_state_t;

endpackage : dma_channel_pkg

// >>> tb/bus_slave_model.sv
`timescale 1ns/1ps
module bus_slave_model (
  input  wire logic                      clock,
  input  wire logic                      slow,
  input  wire dma_channel_pkg::bus_cmd_t bus_cmd,
  output logic                           bus_ack,
  output logic [31:0]                    bus_rdata
);
  import dma_channel_pkg::*;
  logic [31:0] waddr [64];
  logic [31:0] wdata [64];
  logic [1:0]  wsize [64];
  int          wcnt = 0;
  int          rcnt = 0;
  int          stall = 0;
  initial bus_ack = 1'b0;
  initial bus_rdata = 32'h0;
  // data turns over every cycle it is not answering a read, so stale reads show
  always @(posedge clock) begin
    bus_ack <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (bus_cmd.valid && !bus_ack) begin
      if (slow && stall < 3) begin
        stall <= stall + 1;
      end else begin
        stall <= 0;
        bus_ack <= 1'b1;
        if (bus_cmd.write) begin
          waddr[wcnt % 64] <= bus_cmd.addr;
          wdata[wcnt % 64] <= bus_cmd.wdata;
          wsize[wcnt % 64] <= bus_cmd.size;
          wcnt <= wcnt + 1;
        end else begin
          rcnt <= rcnt + 1;
          bus_rdata <= {~bus_cmd.addr[15:0], bus_cmd.addr[15:0]};
        end
      end
    end
  end
endmodule : bus_slave_model

// >>> tb/dma_channel_control_checker.sv
`timescale 1ns/1ps
module dma_channel_control_checker (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic [31:0]               reg_addr,
  input  wire logic                      reg_rd,
  input  wire logic [15:0]               reg_rdata,
  input  wire logic                      trusted_mode,
  input  wire logic                      periph_ack,
  input  wire logic                      bus_want,
  input  wire logic                      bus_hold,
  input  wire dma_channel_pkg::bus_cmd_t bus_cmd,
  input  wire logic                      bus_ack,
  input  wire logic                      irq
);
  import dma_channel_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  property p_rsv;
    reg_rd && reg_addr == OFS_CONTROL |=> reg_rdata[15:14] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits read nonzero");
  property p_trust_rd;
    reg_rd && reg_addr == OFS_CONTROL && trusted_mode
      |=> reg_rdata[12:11] == 2'h0 && !reg_rdata[4] && reg_rdata[2:1] == WIDTH_TRUSTED;
  endproperty
  a_trust_rd: assert property (p_trust_rd) else $error("trusted overrides not shown");
  property p_trust_size;
    bus_cmd.valid && trusted_mode |-> bus_cmd.size == WIDTH_TRUSTED;
  endproperty
  a_trust_size: assert property (p_trust_size) else $error("trusted item size wrong");
  property p_hold;
    bus_cmd.valid |-> bus_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("command issued without owning bus");
  property p_stable;
    bus_cmd.valid && !bus_ack |=> $stable(bus_cmd);
  endproperty
  a_stable: assert property (p_stable) else $error("command changed before ack");
  property p_pack;
    periph_ack |-> $past(bus_ack && bus_cmd.valid && bus_cmd.write);
  endproperty
  a_pack: assert property (p_pack) else $error("request ack without item store");
  property p_irq;
    irq |-> $past(bus_ack && bus_cmd.valid && bus_cmd.write);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not after an item store");
  property p_irq1;
    irq |=> !irq;
  endproperty
  a_irq1: assert property (p_irq1) else $error("interrupt longer than one cycle");
  c_irq: cover property (irq);
  c_pack: cover property (periph_ack);
  c_want: cover property (bus_want);
endmodule : dma_channel_control_checker

bind dma_channel_control dma_channel_control_checker i_dma_channel_control_checker (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .trusted_mode(trusted_mode), .periph_ack(periph_ack),
  .bus_want(bus_want), .bus_hold(bus_hold), .bus_cmd(bus_cmd), .bus_ack(bus_ack), .irq(irq));

// >>> tb/test_dma_channel_control.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); end end
module test_dma_channel_control;
  import dma_channel_pkg::*;
  localparam logic [31:0] SRC = 32'h0000_1000;
  localparam logic [31:0] DST = 32'h0000_2000;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        trusted_mode = 1'b0;
  logic        periph_req = 1'b0;
  logic [7:0]  peer_req = 8'h0;
  logic [23:0] peer_prio = 24'h0;
  logic        slow = 1'b0;
  logic [15:0] reg_rdata, rd;
  logic        periph_ack, bus_want, bus_hold, bus_ack, irq;
  logic [31:0] bus_rdata;
  bus_cmd_t    bus_cmd;
  int          num_errors = 0, check_count = 0, irqs = 0, acks = 0, drops = 0, w;
  logic        hold_q = 1'b0;
  dma_channel_control i_dma_channel_control (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trusted_mode(trusted_mode), .periph_req(periph_req), .periph_ack(periph_ack),
    .peer_req(peer_req), .peer_prio(peer_prio), .bus_want(bus_want), .bus_hold(bus_hold),
    .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .irq(irq));
  bus_slave_model i_bus_slave_model (.clock(clock), .slow(slow), .bus_cmd(bus_cmd),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    irqs += (irq === 1'b1);
    acks += (periph_ack === 1'b1);
    drops += (hold_q === 1'b1 && bus_hold === 1'b0);
    hold_q = bus_hold;
  end
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rdr(input logic [31:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : rdr
  // start a transfer, poll until the channel switches itself off, then check the store log
  task automatic go(input logic [15:0] ctl, input logic [15:0] len, input int ss, input int ds,
                    input logic fill, input int nirq);
    int n, w0, r0, i0;
    logic [15:0] c;
    logic [31:0] a;
    w0 = i_bus_slave_model.wcnt;
    r0 = i_bus_slave_model.rcnt;
    i0 = irqs;
    n = 0;
    c = 16'h0001;
    wr(OFS_LENGTH, len);
    wr(OFS_CONTROL, ctl);
    while (c[0] === 1'b1 && n < 300) begin
      rdr(OFS_CONTROL, c);
      n++;
    end
    `CHK(c[0], 1'b0)
    `CHK(i_bus_slave_model.wcnt - w0, int'(len) + 1)
    `CHK(i_bus_slave_model.rcnt - r0, fill ? 1 : int'(len) + 1)
    for (int i = 0; i <= int'(len); i++) begin
      a = SRC + (fill ? 0 : ss * i);
      `CHK(i_bus_slave_model.waddr[w0 + i], DST + ds * i)
      `CHK(i_bus_slave_model.wdata[w0 + i], ({~a[15:0], a[15:0]}))
      `CHK(i_bus_slave_model.wsize[w0 + i], trusted_mode ? WIDTH_TRUSTED : ctl[2:1])
    end
    `CHK(irqs - i0, nirq)
    rdr(OFS_INDEX, c);
    `CHK(c, 16'h0000)
  endtask : go
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdr(OFS_CONTROL, rd);
    `CHK(rd, CONTROL_RESET)
    wr(OFS_CONTROL, 16'hC000);
    rdr(OFS_CONTROL, rd);
    `CHK(rd, 16'h0000)
    rdr(32'h5000_3580, rd);
    `CHK(rd, 16'h0000)
    wr(OFS_SRC_LO, SRC[15:0]);
    wr(OFS_DST_LO, DST[15:0]);
    wr(OFS_THRESHOLD, 16'h0001);
    for (int k = 0; k < 3; k++) begin
      slow <= (k == 1);
      w = drops;
      go(16'h0069 | (16'(k) << 1), 16'h0002, 1 << k, 1 << k, 1'b0, 1);
      `CHK(drops - w, 1)
    end
    slow <= 1'b0;
    w = drops;
    go(16'h0841, 16'h0001, 1, 0, 1'b0, 0);
    `CHK(drops - w, 2)
    w = drops;
    go(16'h1065, 16'h0003, 4, 4, 1'b1, 0);
    `CHK(drops - w, 1)
    peer_req <= 8'h88;
    peer_prio[11:9] <= 3'h5;
    w = i_bus_slave_model.wcnt;
    fork
      go(16'h0405, 16'h0000, 0, 0, 1'b0, 0);
      begin
        repeat (15) @(posedge clock);
        `CHK(bus_want, 1'b1)
        `CHK(i_bus_slave_model.wcnt - w, 0)
        peer_prio[11:9] <= 3'h4;
        repeat (15) @(posedge clock);
        `CHK(i_bus_slave_model.wcnt - w, 0)
        peer_prio[11:9] <= 3'h3;
      end
    join
    peer_req <= 8'h00;
    trusted_mode <= 1'b1;
    wr(OFS_CONTROL, 16'h180E);
    rdr(OFS_CONTROL, rd);
    `CHK(rd, 16'h000C)
    go(16'h180F, 16'h0001, 0, 0, 1'b0, 1);
    trusted_mode <= 1'b0;
    rdr(OFS_CONTROL, rd);
    `CHK(rd, 16'h180E)
    w = i_bus_slave_model.wcnt;
    fork
      go(16'h0035, 16'h0001, 0, 4, 1'b0, 0);
      begin
        repeat (20) @(posedge clock);
        `CHK(i_bus_slave_model.wcnt - w, 0)
        periph_req <= 1'b1;
      end
    join
    periph_req <= 1'b0;
    `CHK(acks, 2)
    w = i_bus_slave_model.wcnt;
    fork
      go(16'h2035, 16'h0001, 0, 4, 1'b0, 0);
      begin
        repeat (8) @(posedge clock);
        periph_req <= 1'b1;
        repeat (60) @(posedge clock);
        `CHK(i_bus_slave_model.wcnt - w, 1)
        periph_req <= 1'b0;
        repeat (4) @(posedge clock);
        periph_req <= 1'b1;
      end
    join
    periph_req <= 1'b0;
    wr(OFS_LENGTH, 16'h0001);
    periph_req <= 1'b1;
    repeat (4) @(posedge clock);
    periph_req <= 1'b0;
    repeat (4) @(posedge clock);
    w = i_bus_slave_model.wcnt;
    wr(OFS_CONTROL, 16'h20B5);
    repeat (3) begin
      periph_req <= 1'b1;
      repeat (4) @(posedge clock);
      periph_req <= 1'b0;
      repeat (30) @(posedge clock);
    end
    rdr(OFS_CONTROL, rd);
    `CHK(rd[0], 1'b1)
    `CHK(i_bus_slave_model.wcnt - w, 3)
    `CHK(i_bus_slave_model.waddr[w + 2], DST)
    wr(OFS_CONTROL, 16'h0000);
    results();
  end
endmodule : test_dma_channel_control
